// >>> wiper_host.sv
// Host end: APB command registers driving the three-wire serial link
//
// The implementer's own choices: the register addresses and the APB slave port.
`timescale 1ns/100ps
module wiper_host #(
	parameter int SCLK_HALF_P  = wiper_pkg::SCLK_HALF_CYCLES,
	parameter int STORE_HOLD_P = wiper_pkg::STORE_HOLD_CYCLES,
	parameter int SEL_LOW_P    = wiper_pkg::SEL_LOW_CYCLES
) (
	input  wire logic                        pclk,
	input  wire logic                        presetn,
	input  wire logic                        psel,
	input  wire logic                        penable,
	input  wire logic                        pwrite,
	input  wire logic [wiper_pkg::APB_AW-1:0] paddr,
	input  wire logic [31:0]                 pwdata,
	output logic [31:0]                      prdata,
	output logic                             pready,
	output logic                             pslverr,
	output logic                             irq,
	wiper_link.host                          link
);
	import wiper_pkg::*;

	localparam int DW = $clog2(SCLK_HALF_P + SEL_LOW_P + 1);
	localparam int HW = $clog2(STORE_HOLD_P + 1);

	if (SCLK_HALF_P < 1 || STORE_HOLD_P < 1 || SEL_LOW_P < 1) begin : g_param_check
		$error("Host timing parameters must be at least one");
	end

	function automatic logic mapped(input logic [APB_AW-1:0] a);
		return a == CMD_OFS || a == STATUS_OFS || a == IRQ_STATUS_OFS || a == IRQ_MASK_OFS;
	endfunction

	host_state_t       state;
	host_state_t       next_state;
	logic [10:0]       frame;
	logic [10:0]       next_frame;
	logic [3:0]        rise_cnt;
	logic [3:0]        next_rise_cnt;
	logic [DW-1:0]     div_cnt;
	logic [DW-1:0]     next_div_cnt;
	logic [HW-1:0]     hold_cnt;
	logic [HW-1:0]     next_hold_cnt;
	logic [7:0]        rdata;
	logic [7:0]        next_rdata;
	logic              do_store;
	logic              next_do_store;
	logic              rd_only;
	logic              next_rd_only;
	logic              release_sel;
	logic              next_release_sel;
	logic              seen_low;
	logic              next_seen_low;
	logic              sel;
	logic              next_sel;
	logic              sclk;
	logic              next_sclk;
	logic              sdi;
	logic              next_sdi;
	logic              strobe;
	logic              next_strobe;
	logic [IRQ_W-1:0]  irq_st;
	logic [IRQ_W-1:0]  next_irq_st;
	logic [IRQ_W-1:0]  irq_mask;
	logic [IRQ_W-1:0]  next_irq_mask;
	logic [IRQ_W-1:0]  events;
	logic [31:0]       next_prdata;
	logic              next_pready;
	logic              next_pslverr;
	logic              next_irq;
	logic              access;
	logic              tick;

	assign access = psel & penable & pready;
	assign tick   = div_cnt == DW'(SCLK_HALF_P - 1);

	assign link.sel          = sel;
	assign link.sclk         = sclk;
	assign link.serial_in    = sdi;
	assign link.store_strobe = strobe;

	always_comb begin
		next_state       = state;
		next_frame       = frame;
		next_rise_cnt    = rise_cnt;
		next_div_cnt     = div_cnt + DW'(1);
		next_hold_cnt    = hold_cnt;
		next_rdata       = rdata;
		next_do_store    = do_store;
		next_rd_only     = rd_only;
		next_release_sel = release_sel;
		next_seen_low    = seen_low | (strobe & ~link.store_ready_flag);
		next_sel         = sel;
		next_sclk        = sclk;
		next_sdi         = sdi;
		next_strobe      = strobe;
		events           = '0;
		// Clock keeps toggling through the store wait
		// [RULE_11] clock runs during programming
		if ((state == H_SHIFT || state == H_HOLD || state == H_WAIT) && tick) begin
			next_div_cnt = '0;
			next_sclk    = ~sclk;
		end
		// [RULE_08] strobe held for the full store time
		if (strobe) begin
			next_hold_cnt = hold_cnt + HW'(1);
		end
		case (state)
			H_IDLE: begin
				next_div_cnt = '0;
				if (access && pwrite && paddr == CMD_OFS) begin
					// [RULE_16] start bit, address, data LSB first
					// [RULE_17] second address bit sent as zero
					next_frame = {pwdata[CMD_DATA_LSB +: 8], 1'b0, pwdata[CMD_CHAN_BIT], 1'b1};
					next_do_store    = pwdata[CMD_STORE_BIT];
					next_rd_only     = pwdata[CMD_RDONLY_BIT];
					next_release_sel = pwdata[CMD_RELEASE_BIT];
					next_rise_cnt    = 4'h0;
					next_seen_low    = 1'b0;
					next_sel         = 1'b1;
					next_sclk        = 1'b0;
					next_sdi         = 1'b1;
					next_state       = H_SHIFT;
				end
			end
			H_SHIFT: begin
				if (tick && !sclk) begin
					// [RULE_06] bit stands before each rising edge
					next_rise_cnt = rise_cnt + 4'h1;
				end else if (tick) begin
					next_frame = {1'b0, frame[10:1]};
					next_sdi   = frame[1];
					if (rise_cnt >= RISE_ADDR_END && rise_cnt < RISE_LAST) begin
						next_rdata = {link.serial_line, rdata[7:1]};
					end
					// [RULE_09] strobe raised after the start bit
					if (rise_cnt == RISE_START && do_store) begin
						next_strobe   = 1'b1;
						next_hold_cnt = '0;
					end
					// [RULE_13] deselect before the thirteenth clock
					if (rise_cnt == RISE_LAST && rd_only) begin
						events[IRQ_FRAME_BIT] = 1'b1;
						next_state = H_DESEL;
						next_div_cnt = '0;
						next_sel   = 1'b0;
					end else if (rise_cnt == RISE_POST_END) begin
						if (do_store) begin
							next_state = H_HOLD;
						end else begin
							events[IRQ_FRAME_BIT] = 1'b1;
							next_state = release_sel ? H_DESEL : H_IDLE;
							next_div_cnt = '0;
							next_sel   = ~release_sel;
						end
					end
				end
			end
			H_HOLD: begin
				if (hold_cnt >= HW'(STORE_HOLD_P - 1)) begin
					next_strobe = 1'b0;
					next_state  = H_WAIT;
				end
			end
			H_WAIT: begin
				if (link.store_ready_flag) begin
					events[IRQ_FRAME_BIT]  = 1'b1;
					events[IRQ_STORED_BIT] = seen_low;
					events[IRQ_FAILED_BIT] = ~seen_low;
					next_state = release_sel ? H_DESEL : H_IDLE;
					next_div_cnt = '0;
					next_sel   = ~release_sel;
					next_sclk  = 1'b0;
				end
			end
			H_DESEL: begin
				next_sel  = 1'b0;
				next_sclk = 1'b0;
				if (div_cnt == DW'(SEL_LOW_P - 1)) begin
					next_state = H_IDLE;
				end
			end
			default: begin
				next_state = H_IDLE;
			end
		endcase
		// Clear only what the read reported, so a new event is never lost
		next_irq_st = irq_st;
		if (access && !pwrite && paddr == IRQ_STATUS_OFS) begin
			next_irq_st = irq_st & ~prdata[IRQ_W-1:0];
		end
		next_irq_st   = next_irq_st | events;
		next_irq_mask = irq_mask;
		if (access && pwrite && paddr == IRQ_MASK_OFS) begin
			next_irq_mask = pwdata[IRQ_W-1:0];
		end
		next_irq = |(next_irq_st & next_irq_mask);
		// No wait state: pready is high in the first access cycle
		next_pready  = psel & ~penable & ~pready;
		next_pslverr = next_pready & ~mapped(paddr);
		next_prdata  = 32'h0000_0000;
		if (psel && !penable && !pwrite) begin
			case (paddr)
				STATUS_OFS: begin
					next_prdata[ST_BUSY_BIT]        = state != H_IDLE;
					next_prdata[ST_READY_BIT]       = link.store_ready_flag;
					next_prdata[ST_SEL_BIT]         = sel;
					next_prdata[ST_RDATA_LSB +: 8]  = rdata;
				end
				IRQ_STATUS_OFS: next_prdata[IRQ_W-1:0] = irq_st;
				IRQ_MASK_OFS:   next_prdata[IRQ_W-1:0] = irq_mask;
				default:        next_prdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state       <= H_IDLE;
			frame       <= 11'h000;
			rise_cnt    <= 4'h0;
			div_cnt     <= '0;
			hold_cnt    <= '0;
			rdata       <= 8'h00;
			do_store    <= 1'b0;
			rd_only     <= 1'b0;
			release_sel <= 1'b0;
			seen_low    <= 1'b0;
			sel         <= 1'b0;
			sclk        <= 1'b0;
			sdi         <= 1'b0;
			strobe      <= 1'b0;
			irq_st      <= '0;
			irq_mask    <= IRQ_MASK_RESET;
			prdata      <= 32'h0000_0000;
			pready      <= 1'b0;
			pslverr     <= 1'b0;
			irq         <= 1'b0;
		end else begin
			state       <= next_state;
			frame       <= next_frame;
			rise_cnt    <= next_rise_cnt;
			div_cnt     <= next_div_cnt;
			hold_cnt    <= next_hold_cnt;
			rdata       <= next_rdata;
			do_store    <= next_do_store;
			rd_only     <= next_rd_only;
			release_sel <= next_release_sel;
			seen_low    <= next_seen_low;
			sel         <= next_sel;
			sclk        <= next_sclk;
			sdi         <= next_sdi;
			strobe      <= next_strobe;
			irq_st      <= next_irq_st;
			irq_mask    <= next_irq_mask;
			prdata      <= next_prdata;
			pready      <= next_pready;
			pslverr     <= next_pslverr;
			irq         <= next_irq;
		end
	end
endmodule

// >>> wiper_pkg.sv
// Shared constants and state encodings for the dual wiper serial link
package wiper_pkg;
	localparam int CLK_MHZ           = 125;
	// Serial clock half period, from the minimum clock high time
	localparam int SCLK_HIGH_NS      = 500;
	localparam int SCLK_HALF_CYCLES  = (SCLK_HIGH_NS * CLK_MHZ + 999) / 1000;
	localparam int SEL_LOW_NS        = 150;
	localparam int SEL_LOW_CYCLES    = (SEL_LOW_NS * CLK_MHZ + 999) / 1000;
	localparam int STORE_HOLD_MS     = 3;
	localparam int STORE_HOLD_CYCLES = STORE_HOLD_MS * CLK_MHZ * 1000;
	localparam int BUSY_MS           = 4;
	localparam int BUSY_CYCLES       = BUSY_MS * CLK_MHZ * 1000;
	localparam logic [7:0] NV_RESET  = 8'h00;
	localparam logic [3:0] LAST_DATA_IDX = 4'h7;
	// Host edge counts within one frame
	localparam logic [3:0] RISE_START    = 4'h1;
	localparam logic [3:0] RISE_ADDR_END = 4'h3;
	localparam logic [3:0] RISE_LAST     = 4'hb;
	localparam logic [3:0] RISE_POST_END = 4'hd;
	// Host register map
	localparam int APB_AW = 12;
	localparam logic [11:0] CMD_OFS        = 12'h000;
	localparam logic [11:0] STATUS_OFS     = 12'h004;
	localparam logic [11:0] IRQ_STATUS_OFS = 12'h008;
	localparam logic [11:0] IRQ_MASK_OFS   = 12'h00c;
	localparam int CMD_DATA_LSB   = 0;
	localparam int CMD_CHAN_BIT   = 8;
	localparam int CMD_STORE_BIT  = 9;
	localparam int CMD_RDONLY_BIT = 10;
	localparam int CMD_RELEASE_BIT = 11;
	localparam int ST_BUSY_BIT    = 0;
	localparam int ST_READY_BIT   = 1;
	localparam int ST_SEL_BIT     = 2;
	localparam int ST_RDATA_LSB   = 8;
	localparam int IRQ_FRAME_BIT  = 0;
	localparam int IRQ_STORED_BIT = 1;
	localparam int IRQ_FAILED_BIT = 2;
	localparam int IRQ_W          = 3;
	localparam logic [2:0] IRQ_MASK_RESET = 3'h0;

	typedef enum logic [4:0] {
		D_IDLE = 5'b0_0001,
		D_ADDR = 5'b0_0010,
		D_DATA = 5'b0_0100,
		D_POST = 5'b0_1000,
		D_BUSY = 5'b1_0000
	} dev_state_t;

	typedef enum logic [4:0] {
		H_IDLE  = 5'b0_0001,
		H_SHIFT = 5'b0_0010,
		H_HOLD  = 5'b0_0100,
		H_WAIT  = 5'b0_1000,
		H_DESEL = 5'b1_0000
	} host_state_t;
endpackage

// >>> wiper_link.sv
// Three-wire serial link between the host controller and the wiper device
`timescale 1ns/100ps
interface wiper_link;
	logic sel;
	logic sclk;
	logic serial_in;
	logic store_strobe;
	logic serial_out;
	logic serial_out_oe_n;
	logic store_ready_flag;
	logic serial_line;

	// Undriven data line reads high, as with a pull-up
	assign serial_line = serial_out_oe_n ? 1'b1 : serial_out;

	modport device (
		input  sel,
		input  sclk,
		input  serial_in,
		input  store_strobe,
		output serial_out,
		output serial_out_oe_n,
		output store_ready_flag
	);

	modport host (
		output sel,
		output sclk,
		output serial_in,
		output store_strobe,
		input  serial_line,
		input  store_ready_flag
	);
endinterface

// >>> wiper_device.sv
// Device end: serial frame decoder, wiper registers and non-volatile store
//
// Contract
// [RULE_01] Store request drives ready low until done
// [RULE_02] Ignore input, no output data while storing
// [RULE_03] Ready flag ANDed with supply detector
// [RULE_04] After start and address, shift register out
// [RULE_05] Output driven while select high only
// [RULE_06] Host sends start, address, data on rises
// [RULE_07] Output updates on cycle after last bit
// [RULE_08] Host holds store strobe three milliseconds
// [RULE_09] Strobe after start, before post-frame edge
// [RULE_10] Ready for next frame two cycles later
// [RULE_11] Host keeps clock running while storing
// [RULE_12] Every transfer destructively shifts old value out
// [RULE_13] Deselect before thirteenth clock reloads stored value
// [RULE_14] Temporary settings persist; deselect restores both
// [RULE_15] No strobe in two cycles discards data
// [RULE_16] Start bit one, fields shifted LSB first
// [RULE_17] First address bit picks channel, second zero
// [RULE_18] Power-up loads wipers from stored values
`timescale 1ns/100ps
module wiper_device #(
	parameter int         BUSY_CYCLES_P = wiper_pkg::BUSY_CYCLES,
	parameter logic [7:0] NV_INIT       = wiper_pkg::NV_RESET
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	wiper_link.device        link,
	input  wire logic        supply_ok,
	output logic [7:0]       output_channel_one,
	output logic [7:0]       output_channel_two,
	output logic             store_done
);
	import wiper_pkg::*;

	localparam int BW = $clog2(BUSY_CYCLES_P + 1);

	if (BUSY_CYCLES_P < 1) begin : g_busy_check
		$error("BUSY_CYCLES_P must be at least one");
	end

	dev_state_t     state;
	dev_state_t     next_state;
	logic [7:0]     wiper [2];
	logic [7:0]     next_wiper [2];
	logic [7:0]     nv [2];
	logic [7:0]     next_nv [2];
	logic [7:0]     shreg;
	logic [7:0]     next_shreg;
	logic           chan;
	logic           next_chan;
	logic [3:0]     bit_cnt;
	logic [3:0]     next_bit_cnt;
	logic [BW-1:0]  busy_cnt;
	logic [BW-1:0]  next_busy_cnt;
	logic           sclk_q;
	logic           sout;
	logic           next_sout;
	logic           sout_oe_n;
	logic           next_sout_oe_n;
	logic           ready;
	logic           next_ready;
	logic           next_store_done;
	logic           sclk_rise;
	logic           store_go;

	// Inputs are synchronous to pclk, so a registered copy is enough for edges
	assign sclk_rise = link.sclk & ~sclk_q;
	assign store_go  = link.store_strobe & supply_ok;

	assign output_channel_one    = wiper[0];
	assign output_channel_two    = wiper[1];
	assign link.serial_out       = sout;
	assign link.serial_out_oe_n  = sout_oe_n;
	assign link.store_ready_flag = ready;

	always_comb begin
		next_state      = state;
		next_wiper      = wiper;
		next_nv         = nv;
		next_shreg      = shreg;
		next_chan       = chan;
		next_bit_cnt    = bit_cnt;
		next_busy_cnt   = busy_cnt;
		next_store_done = 1'b0;
		case (state)
			D_IDLE: begin
				// [RULE_16] start bit check
				if (sclk_rise && link.sel && link.serial_in) begin
					next_state   = D_ADDR;
					next_bit_cnt = 4'h0;
				end
			end
			D_ADDR: begin
				if (sclk_rise) begin
					if (bit_cnt == 4'h0) begin
						// [RULE_17] channel from first bit
						next_chan    = link.serial_in;
						next_bit_cnt = 4'h1;
					end else begin
						// [RULE_04] load for read-out
						next_shreg   = wiper[chan];
						next_state   = D_DATA;
						next_bit_cnt = 4'h0;
					end
				end
			end
			D_DATA: begin
				if (sclk_rise) begin
					// [RULE_12] old value leaves as new enters
					next_shreg   = {link.serial_in, shreg[7:1]};
					next_bit_cnt = bit_cnt + 4'h1;
					if (bit_cnt == LAST_DATA_IDX) begin
						next_state   = D_POST;
						next_bit_cnt = 4'h0;
					end
				end
			end
			D_POST: begin
				if (sclk_rise) begin
					// [RULE_07] apply on the edge after the last bit
					if (bit_cnt == 4'h0) begin
						next_wiper[chan] = shreg;
					end
					next_bit_cnt = 4'h1;
					// [RULE_01] store request starts the busy period
					if (store_go) begin
						next_state    = D_BUSY;
						next_busy_cnt = BW'(BUSY_CYCLES_P - 1);
					end else if (bit_cnt == 4'h1) begin
						// [RULE_15] no strobe, data discarded
						// [RULE_10] ready for the next start bit
						next_state = D_IDLE;
					end
				end
			end
			D_BUSY: begin
				// [RULE_02] serial input not looked at here
				if (busy_cnt == '0) begin
					next_nv[chan]   = shreg;
					next_store_done = 1'b1;
					next_state      = D_IDLE;
				end else begin
					next_busy_cnt = busy_cnt - BW'(1);
				end
			end
			default: begin
				next_state = D_IDLE;
			end
		endcase
		// A store in progress completes even if select drops meanwhile
		// [RULE_13] deselect reloads stored setting
		// [RULE_14] both channels revert on deselect
		if (!link.sel) begin
			next_wiper[0] = next_nv[0];
			next_wiper[1] = next_nv[1];
			if (state != D_BUSY) begin
				next_state = D_IDLE;
			end
		end
		// [RULE_02] no data on the output while busy
		next_sout      = (next_state == D_DATA) ? next_shreg[0] : 1'b0;
		// [RULE_05] drive follows select
		next_sout_oe_n = ~link.sel;
		// [RULE_03] low only while busy and supply good
		next_ready     = ~((next_state == D_BUSY) && supply_ok);
	end

	// [RULE_18] reset loads wipers from stored values
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state      <= D_IDLE;
			wiper[0]   <= NV_INIT;
			wiper[1]   <= NV_INIT;
			nv[0]      <= NV_INIT;
			nv[1]      <= NV_INIT;
			shreg      <= 8'h00;
			chan       <= 1'b0;
			bit_cnt    <= 4'h0;
			busy_cnt   <= '0;
			sclk_q     <= 1'b0;
			sout       <= 1'b0;
			sout_oe_n  <= 1'b1;
			ready      <= 1'b1;
			store_done <= 1'b0;
		end else begin
			state      <= next_state;
			wiper      <= next_wiper;
			nv         <= next_nv;
			shreg      <= next_shreg;
			chan       <= next_chan;
			bit_cnt    <= next_bit_cnt;
			busy_cnt   <= next_busy_cnt;
			sclk_q     <= link.sclk;
			sout       <= next_sout;
			sout_oe_n  <= next_sout_oe_n;
			ready      <= next_ready;
			store_done <= next_store_done;
		end
	end
endmodule

// >>> wiper_link_asserts.sv
// Concurrent checks on the serial link between the host and the device
`timescale 1ns/100ps
module wiper_link_asserts #(
	parameter int BUSY_CYCLES_P = 400,
	parameter int STORE_HOLD_P  = 300,
	parameter int SCLK_HALF_P   = 4
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic sel,
	input wire logic sclk,
	input wire logic store_strobe,
	input wire logic serial_out,
	input wire logic serial_out_oe_n,
	input wire logic store_ready_flag,
	input wire logic supply_ok
);
	logic [15:0] low_cnt, hi_cnt, still_cnt;
	logic [15:0] next_low_cnt, next_hi_cnt, next_still_cnt;
	logic [2:0]  sclk_d, next_sclk_d;
	logic        rise_seen;

	// Shift updates may land up to two cycles after the rising clock edge
	assign rise_seen = (sclk && !sclk_d[0]) || (sclk_d[0] && !sclk_d[1])
		|| (sclk_d[1] && !sclk_d[2]);

	always_comb begin
		next_low_cnt = store_ready_flag ? 16'h0000 : low_cnt + 16'h0001;
		next_hi_cnt = store_strobe ? hi_cnt + 16'h0001 : 16'h0000;
		next_still_cnt = (sclk == sclk_d[0]) ? still_cnt + 16'h0001 : 16'h0000;
		next_sclk_d = {sclk_d[1:0], sclk};
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			{low_cnt, hi_cnt, still_cnt, sclk_d} <= '0;
		end else begin
			{low_cnt, hi_cnt, still_cnt, sclk_d} <= {next_low_cnt, next_hi_cnt, next_still_cnt, next_sclk_d};
		end
	end

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence busy_start;
		$fell(store_ready_flag);
	endsequence
	sequence busy_end;
		$rose(store_ready_flag);
	endsequence
	property busy_length;
		busy_end |-> low_cnt >= BUSY_CYCLES_P - 1 && low_cnt <= BUSY_CYCLES_P + 1;
	endproperty
	property out_on_rise;
		$changed(serial_out) && sel && $past(sel) && store_ready_flag && $past(store_ready_flag)
			|-> rise_seen;
	endproperty

	AST_READY_CAUSE: assert property (busy_start |-> $past(store_strobe) && $past(supply_ok))
		else $error("ready flag fell without strobe and good supply");
	AST_BUSY_LENGTH: assert property (busy_length)
		else $error("busy period length wrong");
	AST_QUIET_WHILE_BUSY: assert property (!store_ready_flag && !$past(store_ready_flag) |-> !serial_out)
		else $error("data output while storing");
	AST_OE_ON: assert property (sel |=> !serial_out_oe_n)
		else $error("output not driven while selected");
	AST_OE_OFF: assert property (!sel |=> serial_out_oe_n)
		else $error("output still driven after deselect");
	AST_OUT_ON_RISE: assert property (out_on_rise)
		else $error("serial output changed away from a clock rise");
	AST_STROBE_HOLD: assert property ($fell(store_strobe) |-> hi_cnt >= STORE_HOLD_P - 1)
		else $error("store strobe held too briefly");
	AST_CLOCK_RUNS: assert property (!store_ready_flag |-> still_cnt <= SCLK_HALF_P)
		else $error("serial clock stopped during store");
endmodule

// >>> tb_dual_wiper_serial_nv_control.sv
// Self-checking bench: host and device joined over the serial link
`timescale 1ns/100ps
module tb_dual_wiper_serial_nv_control;
	import wiper_pkg::*;
	localparam int HALF = 4;
	localparam int HOLD = 300;
	localparam int BUSY = 400;
	localparam logic [32:0] ALL = 33'h1_ffff_ffff;
	typedef struct {
		string       name;
		logic [32:0] exp;
		logic [32:0] mask;
	} note_t;
	logic              pclk = 1'b0;
	logic              presetn = 1'b0;
	logic              psel = 1'b0;
	logic              penable = 1'b0;
	logic              pwrite = 1'b0;
	logic [APB_AW-1:0] paddr = '0;
	logic [31:0]       pwdata = 32'h0000_0000;
	logic [31:0]       prdata;
	logic              pready, pslverr, irq, store_done;
	logic              supply_ok = 1'b1;
	logic              probe = 1'b0;
	// Only reads that carry a note are compared; status polling is not
	logic              want = 1'b0;
	logic [7:0]        ch1, ch2, v1, v2, v3, v4, v5;
	logic [7:0]        lfsr = 8'h07;
	logic [3:0]        done_cnt = 4'h0;
	logic [32:0]       seen;
	note_t             cur;
	note_t             notes[$];
	int                err_count = 0;
	int                comparisons = 0;

	wiper_link link();
	wiper_host #(.SCLK_HALF_P(HALF), .STORE_HOLD_P(HOLD), .SEL_LOW_P(2)) wiper_host_i (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.irq(irq), .link(link.host));
	wiper_device #(.BUSY_CYCLES_P(BUSY), .NV_INIT(NV_RESET)) wiper_device_i (
		.pclk(pclk), .presetn(presetn), .link(link.device), .supply_ok(supply_ok),
		.output_channel_one(ch1), .output_channel_two(ch2), .store_done(store_done));
	wiper_link_asserts #(.BUSY_CYCLES_P(BUSY), .STORE_HOLD_P(HOLD), .SCLK_HALF_P(HALF))
		wiper_link_asserts_i (
		.pclk(pclk), .presetn(presetn), .sel(link.sel), .sclk(link.sclk),
		.store_strobe(link.store_strobe), .serial_out(link.serial_out),
		.serial_out_oe_n(link.serial_out_oe_n), .store_ready_flag(link.store_ready_flag),
		.supply_ok(supply_ok));

	always #4 pclk = ~pclk;

	always @(posedge pclk) begin
		if (store_done === 1'b1) begin
			done_cnt <= done_cnt + 4'h1;
		end
	end

	// Results are matched against the oldest pending note
	always @(posedge pclk) begin
		if ((psel && penable && pready && !pwrite && want) || probe) begin
			seen = probe ? {12'h000, done_cnt, irq, ch2, ch1} : {pslverr, prdata};
			cur = notes.pop_front();
			comparisons++;
			if ((seen & cur.mask) !== (cur.exp & cur.mask)) begin
				err_count++;
				$display("mismatch %s expected %h seen %h", cur.name, cur.exp & cur.mask, seen & cur.mask);
			end
		end
	end

	function automatic logic [7:0] rnd();
		lfsr = {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
		return lfsr;
	endfunction

	task automatic wrap_up();
		$display("comparisons %0d err_count %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic chk,
			input string nm, input logic [32:0] e, input logic [32:0] m, output logic [31:0] rd);
		int n;
		n = 0;
		if (chk) begin
			notes.push_back('{nm, e, m});
		end
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		want <= chk;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		rd = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		want <= 1'b0;
		if (n >= 50) begin
			err_count++;
			$display("mismatch pready expected 1 seen 0");
			wrap_up();
		end
		@(posedge pclk);
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] s;
		apb(1'b1, a, d, 1'b0, "", '0, '0, s);
	endtask

	task automatic rd(input logic [11:0] a, input string nm, input logic [32:0] e, input logic [32:0] m);
		logic [31:0] s;
		apb(1'b0, a, 32'h0000_0000, 1'b1, nm, e, m, s);
	endtask

	task automatic wait_idle();
		logic [31:0] s;
		int          k;
		k = 0;
		do begin
			apb(1'b0, STATUS_OFS, 32'h0000_0000, 1'b0, "", '0, '0, s);
			k++;
		end while (s[ST_BUSY_BIT] !== 1'b0 && k < 600);
		if (k >= 600) begin
			err_count++;
			$display("mismatch status busy expected 0 seen 1");
			wrap_up();
		end
	endtask

	// Read-only frames also release select, which reloads both wipers
	task automatic frame(input logic c, input logic [7:0] d, input logic st, input logic ro,
			input logic [7:0] old);
		wr(CMD_OFS, {20'h0_0000, ro, ro, st, c, d});
		wait_idle();
		rd(STATUS_OFS, "shifted out value", {17'h0_0000, old, 8'h00}, 33'h1_0000_ff01);
	endtask

	task automatic check_out(input string nm, input logic [32:0] e);
		notes.push_back('{nm, e, ALL});
		probe <= 1'b1;
		@(posedge pclk);
		probe <= 1'b0;
		@(posedge pclk);
	endtask

	initial begin
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		v1 = rnd();
		v2 = rnd();
		v3 = rnd();
		v4 = rnd();
		v5 = rnd();
		check_out("wipers after reset", {12'h000, 4'h0, 1'b0, NV_RESET, NV_RESET});
		rd(STATUS_OFS, "status after reset", 33'h0_0000_0002, 33'h1_0000_0007);
		rd(IRQ_MASK_OFS, "irq mask reset", {30'h0000_0000, IRQ_MASK_RESET}, ALL);
		rd(12'h010, "unmapped read", 33'h1_0000_0000, ALL);
		frame(1'b0, v1, 1'b0, 1'b0, NV_RESET);
		check_out("temporary ch1 masked irq", {12'h000, 4'h0, 1'b0, NV_RESET, v1});
		wr(IRQ_MASK_OFS, 32'h0000_0007);
		check_out("irq unmasked", {12'h000, 4'h0, 1'b1, NV_RESET, v1});
		rd(IRQ_STATUS_OFS, "frame done event", 33'h0_0000_0001, 33'h1_0000_0007);
		check_out("irq cleared by read", {12'h000, 4'h0, 1'b0, NV_RESET, v1});
		frame(1'b1, v2, 1'b0, 1'b0, NV_RESET);
		frame(1'b0, v3, 1'b0, 1'b0, v1);
		check_out("temporary both channels", {12'h000, 4'h0, 1'b1, v2, v3});
		frame(1'b0, 8'h00, 1'b0, 1'b1, v3);
		check_out("deselect restores both", {12'h000, 4'h0, 1'b1, NV_RESET, NV_RESET});
		rd(STATUS_OFS, "select released", 33'h0_0000_0002, 33'h1_0000_0007);
		frame(1'b1, v4, 1'b1, 1'b0, NV_RESET);
		rd(IRQ_STATUS_OFS, "store event", 33'h0_0000_0002, 33'h1_0000_0006);
		frame(1'b1, 8'h00, 1'b0, 1'b1, v4);
		check_out("stored ch2 reloaded", {12'h000, 4'h1, 1'b1, v4, NV_RESET});
		supply_ok <= 1'b0;
		frame(1'b0, v5, 1'b1, 1'b0, NV_RESET);
		rd(IRQ_STATUS_OFS, "failed store event", 33'h0_0000_0004, 33'h1_0000_0006);
		frame(1'b0, 8'h00, 1'b0, 1'b1, v5);
		check_out("failed store not kept", {12'h000, 4'h1, 1'b1, v4, NV_RESET});
		supply_ok <= 1'b1;
		repeat (2) @(posedge pclk);
		if (notes.size() != 0) begin
			err_count++;
			$display("mismatch pending notes expected 0 seen %0d", notes.size());
		end
		wrap_up();
	end
endmodule
